// *** logic/epac_pkg.sv ***
// Constants and types shared by the add-page commit stage and its hash engine
// Assumes 64-bit page words and 4096-byte pages
package epac_pkg;

  // Page geometry
  localparam int unsigned WORD_W     = 64;
  localparam int unsigned IDX_W      = 9;
  localparam int unsigned CNT_W      = 10;
  localparam logic [8:0]  LAST_WORD  = 9'h1ff;
  localparam logic [63:0] PAGE_BYTES = 64'h0000_0000_0000_1000;

  // Security-info layout
  localparam int unsigned SI_W       = 376;
  localparam int unsigned SI_R       = 0;
  localparam int unsigned SI_W_BIT   = 1;
  localparam int unsigned SI_X       = 2;
  localparam int unsigned SI_TYPE_LO = 8;
  localparam int unsigned TYPE_W     = 8;

  // Page type codes
  localparam logic [7:0] THREAD_CONTROL_TYPE     = 8'h01;
  localparam logic [7:0] SHADOW_STACK_FIRST_TYPE = 8'h03;
  localparam logic [7:0] SHADOW_STACK_REST_TYPE  = 8'h04;

  // Thread-control page word positions
  localparam logic [8:0] TCS_STATE_WORD    = 9'h000;
  localparam logic [8:0] TCS_FLAGS_WORD    = 9'h001;
  localparam int unsigned DEBUG_OPT_IN_BIT = 0;
  localparam logic [8:0] TCS_SAVE_IDX_WORD = 9'h003;
  localparam int unsigned SAVE_IDX_W       = 32;
  localparam logic [8:0] TCS_EXIT_PTR_WORD = 9'h005;
  localparam logic [8:0] TCS_PREV_SSP_WORD = 9'h008;
  localparam logic [8:0] TCS_RSVD_FIRST    = 9'h009;

  // Measurement record
  localparam logic [63:0] ADD_RECORD_TAG = 64'h0000_0000_4444_4145;
  localparam logic [63:0] COUNT_STEP     = 64'h0000_0000_0000_0001;
  localparam int unsigned CANON_MSB      = 47;

  // Hash engine
  localparam logic [6:0] LAST_ROUND = 7'h3f;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_COPY  = 4'b0010,
    ST_CHECK = 4'b0100,
    ST_HASH  = 4'b1000
  } epac_state_t;

endpackage

// *** logic/epac_sha.sv ***
// One-block hash compression engine, one round per clock
// Assumes start is a one-cycle pulse while idle and inputs hold until done
`timescale 1ns/1ps
`default_nettype none

module epac_sha (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Request
  input  wire logic         start,
  input  wire logic [255:0] h_in,
  input  wire logic [511:0] block,
  // Answer
  output logic              done,
  output logic [255:0]      h_out
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [6:0]       rnd;
    logic [7:0][31:0] v;
    logic [15:0][31:0] w;
    logic [7:0][31:0] h;
  } epac_sha_regs_t;

  localparam logic [31:0] K [64] = '{
    32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, 32'h3956_c25b, 32'h59f1_11f1,
    32'h923f_82a4, 32'hab1c_5ed5, 32'hd807_aa98, 32'h1283_5b01, 32'h2431_85be, 32'h550c_7dc3,
    32'h72be_5d74, 32'h80de_b1fe, 32'h9bdc_06a7, 32'hc19b_f174, 32'he49b_69c1, 32'hefbe_4786,
    32'h0fc1_9dc6, 32'h240c_a1cc, 32'h2de9_2c6f, 32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da,
    32'h983e_5152, 32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7, 32'hc6e0_0bf3, 32'hd5a7_9147,
    32'h06ca_6351, 32'h1429_2967, 32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc, 32'h5338_0d13,
    32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85, 32'ha2bf_e8a1, 32'ha81a_664b,
    32'hc24b_8b70, 32'hc76c_51a3, 32'hd192_e819, 32'hd699_0624, 32'hf40e_3585, 32'h106a_a070,
    32'h19a4_c116, 32'h1e37_6c08, 32'h2748_774c, 32'h34b0_bcb5, 32'h391c_0cb3, 32'h4ed8_aa4a,
    32'h5b9c_ca4f, 32'h682e_6ff3, 32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208,
    32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7, 32'hc671_78f2
  };

  function automatic logic [31:0] rotr(input logic [31:0] x, input int unsigned s);
    rotr = (x >> s) | (x << (32 - s));
  endfunction

  function automatic logic [31:0] bswap(input logic [31:0] x);
    bswap = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  epac_sha_regs_t   q;
  epac_sha_regs_t   n;
  logic [31:0]      t1;
  logic [31:0]      t2;
  logic [31:0]      wn;
  logic [7:0][31:0] vn;

  always_comb begin
    n      = q;
    n.done = 1'b0;
    t1     = q.v[0] + (rotr(q.v[3], 6) ^ rotr(q.v[3], 11) ^ rotr(q.v[3], 25))
           + ((q.v[3] & q.v[2]) ^ (~q.v[3] & q.v[1])) + K[q.rnd[5:0]] + q.w[0];
    t2     = (rotr(q.v[7], 2) ^ rotr(q.v[7], 13) ^ rotr(q.v[7], 22))
           + ((q.v[7] & q.v[6]) ^ (q.v[7] & q.v[5]) ^ (q.v[6] & q.v[5]));
    wn     = (rotr(q.w[14], 17) ^ rotr(q.w[14], 19) ^ (q.w[14] >> 10)) + q.w[9]
           + (rotr(q.w[1], 7) ^ rotr(q.w[1], 18) ^ (q.w[1] >> 3)) + q.w[0];
    vn     = {t1 + t2, q.v[7], q.v[6], q.v[5], q.v[4] + t1, q.v[3], q.v[2], q.v[1]};
    if (start && !q.busy) begin
      n.busy = 1'b1;
      n.rnd  = '0;
      n.v    = h_in;
      n.h    = h_in;
      for (int i = 0; i < 16; i++) begin
        n.w[i] = bswap(block[32*i +: 32]);
      end
    end else if (q.busy) begin
      n.v   = vn;
      n.w   = {wn, q.w[15:1]};
      n.rnd = q.rnd + 7'h01;
      if (q.rnd == epac_pkg::LAST_ROUND) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        for (int i = 0; i < 8; i++) begin
          n.h[i] = q.h[i] + vn[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done  = q.done;
  assign h_out = q.h;

endmodule

`default_nettype wire

// *** logic/epac_commit.sv ***
// Add-page commit stage: page copy, final checks, measurement update, map entry write
// Assumes all inputs share clk and page memory answers one cycle after a read strobe
`timescale 1ns/1ps
`default_nettype none

module epac_commit (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Request
  input  wire logic         start,
  input  wire logic         long_mode,
  input  wire logic         wide_mode_attribute,
  input  wire logic [63:0]  lin_addr,
  input  wire logic [63:0]  info_addr,
  input  wire logic [63:0]  src_page_addr,
  input  wire logic [63:0]  ctrl_page_addr,
  input  wire logic [63:0]  sec_info_addr,
  input  wire logic [63:0]  dst_page_addr,
  input  wire logic [375:0] page_security_info,
  // Enclave state
  input  wire logic [63:0]  range_base,
  input  wire logic [63:0]  range_size,
  input  wire logic         ctrl_initialized,
  input  wire logic [63:0]  owner_id,
  input  wire logic [255:0] meas_in,
  input  wire logic [63:0]  meas_count_in,
  // Concurrency and fault sources
  input  wire logic         operand_locked,
  input  wire logic         measure_busy,
  input  wire logic         dst_map_valid,
  input  wire logic         mem_fault,
  // Source page read port
  output logic              src_rd,
  output logic [8:0]        src_addr,
  input  wire logic [63:0]  src_data,
  // Destination page write port
  output logic              dst_we,
  output logic [8:0]        dst_addr,
  output logic [63:0]       dst_data,
  // Completion
  output logic              busy,
  output logic              done,
  output logic              general_protection_fault,
  output logic              page_fault,
  output logic              flags_write,
  // Measurement update
  output logic              meas_we,
  output logic [255:0]      meas_out,
  output logic [63:0]       meas_count_out,
  // Page map entry write
  output logic              map_we,
  output logic              map_r,
  output logic              map_w,
  output logic              map_x,
  output logic [7:0]        map_type,
  output logic [63:0]       map_lin_addr,
  output logic [63:0]       map_owner,
  output logic              map_blocked,
  output logic              map_pending,
  output logic              map_modified,
  output logic              map_valid
);

  typedef struct packed {
    epac_pkg::epac_state_t st;
    logic [9:0]            cnt;
    logic                  rd_v;
    logic [8:0]            rd_idx;
    logic [7:0]            ptype;
    logic                  r;
    logic                  w;
    logic                  x;
    logic                  bad_ss;
    logic                  bad_tcs;
    logic                  busy;
    logic                  done;
    logic                  gp;
    logic                  pf;
    logic                  flags_wr;
    logic                  src_rd;
    logic [8:0]            src_addr;
    logic                  dst_we;
    logic [8:0]            dst_addr;
    logic [63:0]           dst_data;
    logic                  sha_go;
    logic                  meas_we;
    logic [255:0]          meas;
    logic [63:0]           meas_cnt;
    logic                  map_we;
    logic                  map_r;
    logic                  map_w;
    logic                  map_x;
    logic [7:0]            map_type;
    logic [63:0]           map_lin;
    logic [63:0]           map_owner;
    logic                  map_blocked;
    logic                  map_pending;
    logic                  map_modified;
    logic                  map_valid;
  } epac_regs_t;

  // Wide-mode canonical form check
  function automatic logic non_canon(input logic wide, input logic [63:0] a);
    non_canon = wide && !((&a[63:epac_pkg::CANON_MSB]) || !(|a[63:epac_pkg::CANON_MSB]));
  endfunction

  // Thread-control control fields forced to zero on the way in
  function automatic logic [63:0] tcs_scrub(input logic [8:0] idx, input logic [63:0] d);
    tcs_scrub = d;
    if (idx == epac_pkg::TCS_STATE_WORD || idx == epac_pkg::TCS_EXIT_PTR_WORD) begin
      tcs_scrub = '0;
    end
    if (idx == epac_pkg::TCS_FLAGS_WORD) begin
      tcs_scrub[epac_pkg::DEBUG_OPT_IN_BIT] = 1'b0;
    end
    if (idx == epac_pkg::TCS_SAVE_IDX_WORD) begin
      tcs_scrub[epac_pkg::SAVE_IDX_W-1:0] = '0;
    end
  endfunction

  epac_regs_t       q;
  epac_regs_t       n;
  logic             is_tcs;
  logic             is_ss;
  logic             is_first;
  logic             pre_gp;
  logic             check_gp;
  logic             ss_word_bad;
  logic             tcs_word_bad;
  logic [63:0]      token;
  logic [63:0]      last_page;
  logic [64:0]      range_end;
  logic [63:0]      encl_offset;
  logic [375:0]     si_mod;
  logic [511:0]     record;
  logic             sha_done;
  logic [255:0]     sha_digest;

  assign is_tcs    = q.ptype == epac_pkg::THREAD_CONTROL_TYPE;
  assign is_first  = q.ptype == epac_pkg::SHADOW_STACK_FIRST_TYPE;
  assign is_ss     = is_first || q.ptype == epac_pkg::SHADOW_STACK_REST_TYPE;
  assign token     = (lin_addr + epac_pkg::PAGE_BYTES) | {63'h0, wide_mode_attribute};
  assign range_end = {1'b0, range_base} + {1'b0, range_size};
  assign last_page = range_end[63:0] - epac_pkg::PAGE_BYTES;
  assign encl_offset = lin_addr - range_base;

  // Checks on an incoming page word
  always_comb begin
    ss_word_bad  = src_data != '0;
    if (q.rd_idx == epac_pkg::LAST_WORD) begin
      ss_word_bad = is_first ? (src_data != token)
                             : (src_data != '0);
    end
    tcs_word_bad = 1'b0;
    if (q.rd_idx == epac_pkg::TCS_PREV_SSP_WORD && src_data != '0) begin
      tcs_word_bad = 1'b1;
    end
    if (q.rd_idx >= epac_pkg::TCS_RSVD_FIRST && src_data != '0) begin
      tcs_word_bad = 1'b1;
    end
  end

  // Checks at request time
  always_comb begin
    pre_gp = non_canon(long_mode, lin_addr) || non_canon(long_mode, info_addr);
    pre_gp = pre_gp || non_canon(long_mode, src_page_addr);
    pre_gp = pre_gp || non_canon(long_mode, ctrl_page_addr);
    pre_gp = pre_gp || non_canon(long_mode, sec_info_addr);
    pre_gp = pre_gp || non_canon(long_mode, dst_page_addr);
    pre_gp = pre_gp || operand_locked;
  end

  // Final checks after the copy
  always_comb begin
    check_gp = 1'b0;
    if (is_tcs && q.bad_tcs) begin
      check_gp = 1'b1;
    end
    if (is_ss && (lin_addr == range_base || lin_addr == last_page)) begin
      check_gp = 1'b1;
    end
    if (is_ss && q.bad_ss) begin
      check_gp = 1'b1;
    end
    if (is_ss && !(q.r && q.w && !q.x)) begin
      check_gp = 1'b1;
    end
    if ({1'b0, lin_addr} < {1'b0, range_base} || {1'b0, lin_addr} >= range_end) begin
      check_gp = 1'b1;
    end
    if (measure_busy) begin
      check_gp = 1'b1;
    end
    if (ctrl_initialized) begin
      check_gp = 1'b1;
    end
  end

  // Measurement record with the permissions as they will be committed
  always_comb begin
    si_mod                     = page_security_info;
    si_mod[epac_pkg::SI_R]     = q.r;
    si_mod[epac_pkg::SI_W_BIT] = q.w;
    si_mod[epac_pkg::SI_X]     = q.x;
  end
  assign record = {8'h00, si_mod, encl_offset, epac_pkg::ADD_RECORD_TAG};

  epac_sha u_sha (
    .clk   (clk),
    .rstn  (rstn),
    .start (q.sha_go),
    .h_in  (meas_in),
    .block (record),
    .done  (sha_done),
    .h_out (sha_digest)
  );

  always_comb begin
    n          = q;
    n.done     = 1'b0;
    n.gp       = 1'b0;
    n.pf       = 1'b0;
    n.flags_wr = 1'b0;
    n.src_rd   = 1'b0;
    n.dst_we   = 1'b0;
    n.sha_go   = 1'b0;
    n.meas_we  = 1'b0;
    n.map_we   = 1'b0;
    unique case (q.st)
      epac_pkg::ST_IDLE: begin
        n.rd_v = 1'b0;
        if (start) begin
          n.ptype   = page_security_info[epac_pkg::SI_TYPE_LO +: epac_pkg::TYPE_W];
          n.r       = page_security_info[epac_pkg::SI_R];
          n.w       = page_security_info[epac_pkg::SI_W_BIT];
          n.x       = page_security_info[epac_pkg::SI_X];
          n.bad_ss  = 1'b0;
          n.bad_tcs = 1'b0;
          n.cnt     = '0;
          if (pre_gp) begin
            n.gp   = 1'b1;
            n.done = 1'b1;
          end else if (dst_map_valid || mem_fault) begin
            n.pf   = 1'b1;
            n.done = 1'b1;
          end else begin
            n.busy = 1'b1;
            n.st   = epac_pkg::ST_COPY;
          end
        end
      end
      epac_pkg::ST_COPY: begin
        if (!q.cnt[epac_pkg::IDX_W]) begin
          n.src_rd   = 1'b1;
          n.src_addr = q.cnt[epac_pkg::IDX_W-1:0];
          n.cnt      = q.cnt + 10'h001;
        end
        n.rd_v   = q.src_rd;
        n.rd_idx = q.src_addr;
        if (q.rd_v) begin
          n.dst_we   = 1'b1;
          n.dst_addr = q.rd_idx;
          n.dst_data = is_tcs ? tcs_scrub(q.rd_idx, src_data) : src_data;
          n.bad_ss   = q.bad_ss || ss_word_bad;
          n.bad_tcs  = q.bad_tcs || tcs_word_bad;
          if (q.rd_idx == epac_pkg::LAST_WORD) begin
            n.st = epac_pkg::ST_CHECK;
          end
        end
        if (mem_fault) begin
          n.pf     = 1'b1;
          n.done   = 1'b1;
          n.busy   = 1'b0;
          n.src_rd = 1'b0;
          n.dst_we = 1'b0;
          n.st     = epac_pkg::ST_IDLE;
        end
      end
      epac_pkg::ST_CHECK: begin
        if (check_gp) begin
          n.gp   = 1'b1;
          n.done = 1'b1;
          n.busy = 1'b0;
          n.st   = epac_pkg::ST_IDLE;
        end else begin
          if (is_tcs) begin
            n.r = 1'b0;
            n.w = 1'b0;
            n.x = 1'b0;
          end
          n.sha_go = 1'b1;
          n.st     = epac_pkg::ST_HASH;
        end
      end
      epac_pkg::ST_HASH: begin
        if (sha_done) begin
          n.meas_we      = 1'b1;
          n.meas         = sha_digest;
          n.meas_cnt     = meas_count_in + epac_pkg::COUNT_STEP;
          n.map_we       = 1'b1;
          n.map_r        = q.r;
          n.map_w        = q.w;
          n.map_x        = q.x;
          n.map_type     = q.ptype;
          n.map_lin      = lin_addr;
          n.map_owner    = owner_id;
          n.map_blocked  = 1'b0;
          n.map_pending  = 1'b0;
          n.map_modified = 1'b0;
          n.map_valid    = 1'b1;
          n.done         = 1'b1;
          n.busy         = 1'b0;
          n.st           = epac_pkg::ST_IDLE;
        end
      end
      default: begin
        n.st   = epac_pkg::ST_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q    <= '0;
      q.st <= epac_pkg::ST_IDLE;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign src_rd                   = q.src_rd;
  assign src_addr                 = q.src_addr;
  assign dst_we                   = q.dst_we;
  assign dst_addr                 = q.dst_addr;
  assign dst_data                 = q.dst_data;
  assign busy                     = q.busy;
  assign done                     = q.done;
  assign general_protection_fault = q.gp;
  assign page_fault               = q.pf;
  assign flags_write              = q.flags_wr;
  assign meas_we                  = q.meas_we;
  assign meas_out                 = q.meas;
  assign meas_count_out           = q.meas_cnt;
  assign map_we                   = q.map_we;
  assign map_r                    = q.map_r;
  assign map_w                    = q.map_w;
  assign map_x                    = q.map_x;
  assign map_type                 = q.map_type;
  assign map_lin_addr             = q.map_lin;
  assign map_owner                = q.map_owner;
  assign map_blocked              = q.map_blocked;
  assign map_pending              = q.map_pending;
  assign map_modified             = q.map_modified;
  assign map_valid                = q.map_valid;

endmodule

`default_nettype wire

// *** tb/epac_commit_properties.sv ***
// Port checker for the add-page commit stage
// Assumes one clock domain and binding onto epac_commit
`timescale 1ns/1ps
`default_nettype none
module epac_commit_props (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rstn,
  // Request side
  input wire logic         start,
  input wire logic         operand_locked,
  input wire logic [375:0] page_security_info,
  input wire logic [63:0]  lin_addr,
  input wire logic [63:0]  owner_id,
  input wire logic [63:0]  meas_count_in,
  // Page ports
  input wire logic         src_rd,
  input wire logic [8:0]   src_addr,
  input wire logic         dst_we,
  input wire logic [8:0]   dst_addr,
  // Completion and commit
  input wire logic         busy,
  input wire logic         done,
  input wire logic         general_protection_fault,
  input wire logic         page_fault,
  input wire logic         flags_write,
  input wire logic         meas_we,
  input wire logic [63:0]  meas_count_out,
  input wire logic         map_we,
  input wire logic         map_r,
  input wire logic         map_w,
  input wire logic         map_x,
  input wire logic [7:0]   map_type,
  input wire logic [63:0]  map_lin_addr,
  input wire logic [63:0]  map_owner,
  input wire logic         map_blocked,
  input wire logic         map_pending,
  input wire logic         map_modified,
  input wire logic         map_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire fault = general_protection_fault | page_fault;
  a_fault_aborts: assert property (fault |-> done && !meas_we && !map_we)
    else $error("fault with commit");
  a_commit_clean: assert property (map_we |-> done && meas_we && !fault)
    else $error("commit not clean");
  a_no_flags: assert property (!flags_write)
    else $error("flags written");
  a_lock_gp: assert property (start && !busy && !done && operand_locked
    |=> general_protection_fault && done)
    else $error("locked operand not refused");
  a_entry_bits: assert property (map_we |-> map_valid && !map_blocked && !map_pending
    && !map_modified)
    else $error("entry state bits wrong");
  a_entry_fields: assert property (map_we |-> map_lin_addr == lin_addr
    && map_type == page_security_info[15:8])
    else $error("entry fields wrong");
  a_entry_owner: assert property (map_we |-> map_owner == owner_id)
    else $error("entry owner wrong");
  a_tcs_perm: assert property (map_we && map_type == epac_pkg::THREAD_CONTROL_TYPE
    |-> !map_r && !map_w && !map_x)
    else $error("thread page kept rights");
  a_ss_perm: assert property (map_we && (map_type == epac_pkg::SHADOW_STACK_FIRST_TYPE
    || map_type == epac_pkg::SHADOW_STACK_REST_TYPE) |-> map_r && map_w && !map_x)
    else $error("stack page rights wrong");
  a_count_step: assert property (meas_we
    |-> meas_count_out == meas_count_in + epac_pkg::COUNT_STEP)
    else $error("count not stepped");
  a_copy_step: assert property (src_rd && $past(src_rd)
    |-> src_addr == $past(src_addr) + 9'h001)
    else $error("read order broken");
  a_copy_echo: assert property (dst_we |-> $past(src_rd, 2)
    && dst_addr == $past(src_addr, 2))
    else $error("write not after read");
  c_commit: cover property (map_we);
  c_gp: cover property (general_protection_fault);
  c_pf: cover property (page_fault);
endmodule
bind epac_commit epac_commit_props chk_u (.clk, .rstn, .start, .operand_locked,
  .page_security_info, .lin_addr, .owner_id, .meas_count_in, .src_rd, .src_addr, .dst_we,
  .dst_addr, .busy, .done, .general_protection_fault, .page_fault, .flags_write, .meas_we,
  .meas_count_out, .map_we, .map_r, .map_w, .map_x, .map_type, .map_lin_addr, .map_owner,
  .map_blocked, .map_pending, .map_modified, .map_valid);
`default_nettype wire

// *** tb/enclave_page_add_commit_tb.sv ***
// Self-checking bench for the add-page commit stage
// Assumes a one-cycle page memory modelled here and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module enclave_page_add_commit_tb;
  logic         clk = 1'b0, rstn = 1'b0, start = 1'b0, lmode = 1'b0, wide = 1'b0;
  logic         lock = 1'b0, mbusy = 1'b0, mvalid = 1'b0, mfault = 1'b0, init = 1'b0;
  logic [63:0]  base = 64'h0000_0000_0010_0000, size = 64'h0000_0000_0001_0000;
  logic [63:0]  lin = 64'h0000_0000_0010_2000, ctl = 64'h0, own = 64'h0000_0000_0000_0abc;
  logic [63:0]  cnt = 64'h0000_0000_0000_0007, sdata = 64'h0;
  logic [375:0] si = 376'h0;
  logic         src_rd, dst_we, busy, done, gp, pf, fw, mwe, map_we, mr, mw, mx, mb, mp, mm, mv;
  logic [8:0]   src_addr, dst_addr;
  logic [7:0]   mtype;
  logic [63:0]  dst_data, cnt_out, mlin, mown;
  logic [255:0] mout, mref;
  logic [63:0]  mem [512];
  logic [63:0]  dst [512];
  int           mismatches = 0, compares = 0, n;

  always #2.5 clk = ~clk;
  // Page memory with one cycle of read latency
  always @(posedge clk) sdata <= mem[src_addr];
  always @(posedge clk) if (dst_we) dst[dst_addr] <= dst_data;

  epac_commit dut_u (
    .clk, .rstn, .start, .long_mode(lmode), .wide_mode_attribute(wide), .lin_addr(lin),
    .info_addr(64'h0), .src_page_addr(64'h0), .ctrl_page_addr(ctl), .sec_info_addr(64'h0),
    .dst_page_addr(64'h0), .page_security_info(si), .range_base(base), .range_size(size),
    .ctrl_initialized(init), .owner_id(own), .meas_in(256'h0), .meas_count_in(cnt),
    .operand_locked(lock), .measure_busy(mbusy), .dst_map_valid(mvalid), .mem_fault(mfault),
    .src_rd, .src_addr, .src_data(sdata), .dst_we, .dst_addr, .dst_data, .busy, .done,
    .general_protection_fault(gp), .page_fault(pf), .flags_write(fw), .meas_we(mwe),
    .meas_out(mout), .meas_count_out(cnt_out), .map_we, .map_r(mr), .map_w(mw), .map_x(mx),
    .map_type(mtype), .map_lin_addr(mlin), .map_owner(mown), .map_blocked(mb),
    .map_pending(mp), .map_modified(mm), .map_valid(mv));

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Fill source page, issue one request, judge outcome and latency
  task automatic go(input logic [7:0] pt, input logic [2:0] rwx, input int f,
                    input logic [63:0] top, input logic [1:0] e, input int lat);
    for (int i = 0; i < 512; i++) begin
      mem[i] = (f == 0) ? (64'(i) | 64'ha5a5_0000_0000_0000) : 64'h0;
      if (f >= 2 && i < 6) mem[i] = 64'h0000_0000_ffff_ffff;
    end
    if (f == 3) mem[8] = 64'h0000_0000_0000_0001;
    if (f == 4) mem[3] = 64'h0000_0000_0000_0100;
    mem[511] = top;
    @(posedge clk);
    si <= {360'h0, pt, 5'h00, rwx};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 700) begin
      @(posedge clk);
      n++;
      #1;
    end
    chk("latency", 64'(lat), 64'(n));
    chk("gp", 64'(e[1]), 64'(gp));
    chk("pf", 64'(e[0]), 64'(pf));
    chk("map_we", 64'(e == 2'b00), 64'(map_we));
  endtask

  task automatic t_pre();
    @(posedge clk);
    lock <= 1'b1;
    mvalid <= 1'b1;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 0);
    @(posedge clk);
    lock <= 1'b0;
    go(8'h00, 3'b011, 0, 64'h0, 2'b01, 0);
    @(posedge clk);
    mvalid <= 1'b0;
    mfault <= 1'b1;
    go(8'h00, 3'b011, 0, 64'h0, 2'b01, 0);
    @(posedge clk);
    mfault <= 1'b0;
    lmode <= 1'b1;
    ctl <= 64'h0000_8000_0000_0000;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 0);
    $display("test pre done");
  endtask

  task automatic t_reg();
    @(posedge clk);
    ctl <= 64'hffff_8000_0000_0000;
    go(8'h00, 3'b011, 0, 64'ha5a5_0000_0000_01ff, 2'b00, 581);
    chk("map_rwx", 64'h3, 64'({mx, mw, mr}));
    chk("map_lin", lin, mlin);
    chk("map_type", 64'h0, 64'(mtype));
    chk("map_owner", own, mown);
    chk("map_state", 64'h8, 64'({mv, mb, mp, mm}));
    chk("count", cnt + 64'h0000_0000_0000_0001, cnt_out);
    mref = mout;
    for (int i = 0; i < 512; i++) chk("dst_word", mem[i], dst[i]);
    $display("test reg done");
  endtask

  task automatic t_tcs();
    go(8'h01, 3'b111, 2, 64'h0, 2'b00, 581);
    chk("tcs_rwx", 64'h0, 64'({mx, mw, mr}));
    chk("tcs_state", 64'h0, dst[0]);
    chk("tcs_flags", 64'h0000_0000_ffff_fffe, dst[1]);
    chk("tcs_kept", 64'h0000_0000_ffff_ffff, dst[2]);
    chk("tcs_index", 64'h0, dst[3]);
    chk("tcs_exit", 64'h0, dst[5]);
    go(8'h01, 3'b000, 3, 64'h0, 2'b10, 515);
    go(8'h01, 3'b000, 2, 64'h0000_0000_0000_0001, 2'b10, 515);
    chk("count_held", cnt + 64'h0000_0000_0000_0001, cnt_out);
    $display("test tcs done");
  endtask

  task automatic t_ss();
    @(posedge clk);
    wide <= 1'b1;
    go(8'h03, 3'b011, 1, lin + 64'h0000_0000_0000_1001, 2'b00, 581);
    chk("ss_rwx", 64'h3, 64'({mx, mw, mr}));
    go(8'h03, 3'b011, 1, lin + 64'h0000_0000_0000_1000, 2'b10, 515);
    go(8'h04, 3'b011, 1, 64'h0, 2'b00, 581);
    go(8'h04, 3'b011, 1, 64'h0000_0000_0000_0008, 2'b10, 515);
    go(8'h04, 3'b011, 4, 64'h0, 2'b10, 515);
    go(8'h04, 3'b111, 1, 64'h0, 2'b10, 515);
    go(8'h04, 3'b001, 1, 64'h0, 2'b10, 515);
    @(posedge clk);
    lin <= base;
    go(8'h04, 3'b011, 1, 64'h0, 2'b10, 515);
    @(posedge clk);
    lin <= base + size - 64'h0000_0000_0000_1000;
    go(8'h04, 3'b011, 1, 64'h0, 2'b10, 515);
    go(8'h00, 3'b011, 0, 64'h0, 2'b00, 581);
    chk("meas_offset", 64'h1, 64'(mout != mref));
    mref = mout;
    $display("test ss done");
  endtask

  task automatic t_rng();
    @(posedge clk);
    lin <= base - 64'h0000_0000_0000_1000;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 515);
    @(posedge clk);
    lin <= base + size;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 515);
    @(posedge clk);
    lin <= base + 64'h0000_0000_0000_2000;
    mbusy <= 1'b1;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 515);
    @(posedge clk);
    mbusy <= 1'b0;
    init <= 1'b1;
    go(8'h00, 3'b011, 0, 64'h0, 2'b10, 515);
    chk("lin_held", base + size - 64'h0000_0000_0000_1000, mlin);
    chk("meas_held", 64'h1, 64'(mout == mref));
    $display("test range done");
  endtask

  task automatic t_mfc();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (10) @(posedge clk);
    mfault <= 1'b1;
    @(posedge clk);
    mfault <= 1'b0;
    #1;
    chk("copy_fault", 64'h6, 64'({done, pf, map_we}));
    $display("test copy fault done");
  endtask

  initial begin
    #100000;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_pre();
    t_reg();
    t_tcs();
    t_ss();
    t_rng();
    t_mfc();
    stop_test();
  end
endmodule
`default_nettype wire
